// ==== bancfg_bank.sv ====
// APB register bank for the building automation network settings
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bancfg_params.svh"
module bancfg_bank
  import bancfg_pkg::*;
#(
  parameter logic [15:0] IDENT_CODE = 16'h0123, // Arbitrary value
  parameter logic [15:0] FW_MAJMIN = 16'h0065, // Arbitrary value, xx.yy times 100
  parameter logic [15:0] FW_SUB = 16'h0000 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic msgValid,
  output bancfg_eff_type effCfg,
  output logic netEnable
);
  logic [15:0] nodeAddr;
  logic [15:0] baudCode;
  logic [15:0] protoCode;
  logic [15:0] msgCount;
  logic [15:0] maxMaster;
  logic [15:0] objectId;
  logic pendSlot;

  wire logic [1:0] protoSel;
  wire logic [16:0] baudRate;
  wire logic [15:0] nodeUsed;
  wire logic setupPhase;
  wire logic accessPhase;
  wire logic wrStrobe;
  wire logic rdStrobe;
  wire logic mapped;
  wire logic [15:0] wrData;
  wire logic [15:0] next_maxMaster;
  wire logic [15:0] next_objectId;
  wire logic [15:0] next_msgCount;
  wire logic [15:0] objectUsed;
  logic [31:0] rdMux;

  bancfg_resolve uResolve (
    .protoCode(protoCode),
    .baudCode(baudCode),
    .nodeAddr(nodeAddr),
    .protoSel(protoSel),
    .baudRate(baudRate),
    .nodeUsed(nodeUsed)
  );

  // Bus decode; one wait state so read data comes from a flop
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrStrobe = accessPhase && pready && pwrite && mapped;
  assign rdStrobe = setupPhase && !pwrite;
  assign wrData = pwdata[15:0];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `BAN_OFS_EFFCFG);

  // Clamped values computed before storage so readback shows them
  assign next_maxMaster = (wrData > `BAN_MAXMST_LIMIT) ? `BAN_MAXMST_LIMIT : wrData;
  // Signed compare: anything below -19 stores 1
  assign next_objectId = ($signed(wrData) < $signed(`BAN_OBJID_MIN)) ?
                         `BAN_OBJID_FORCED : wrData;
  assign objectUsed = (objectId == 16'h0000) ? nodeUsed : objectId;
  // Wrap to zero on the message after 9999
  assign next_msgCount = (msgCount >= `BAN_CNT_MAX) ? 16'h0000 : msgCount + 16'h0001;

  // Read mux
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `BAN_OFS_IDENT: rdMux = {16'h0000, IDENT_CODE};
      `BAN_OFS_FWMM: rdMux = {16'h0000, FW_MAJMIN};
      `BAN_OFS_FWSUB: rdMux = {16'h0000, FW_SUB};
      `BAN_OFS_NODE: rdMux = {16'h0000, nodeAddr};
      `BAN_OFS_BAUD: rdMux = {16'h0000, baudCode};
      `BAN_OFS_PROTO: rdMux = {16'h0000, protoCode};
      `BAN_OFS_MSGCNT: rdMux = {16'h0000, msgCount};
      `BAN_OFS_MAXMST: rdMux = {16'h0000, maxMaster};
      `BAN_OFS_OBJID: rdMux = {16'h0000, objectId};
      `BAN_OFS_EFFNODE: rdMux = {16'h0000, nodeUsed};
      `BAN_OFS_EFFCFG: rdMux = {13'h0000, protoSel, baudRate};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Handshake: ready in the second access cycle, error for unmapped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendSlot <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pendSlot <= setupPhase;
      pready <= pendSlot && accessPhase && !pready;
      pslverr <= pendSlot && accessPhase && !pready && !mapped;
      if (rdStrobe) begin
        prdata <= mapped ? rdMux : 32'h0000_0000;
      end
    end
  end

  // Writable settings; read-only offsets ignore writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nodeAddr <= `BAN_RST_NODE;
      baudCode <= `BAN_RST_BAUD;
      protoCode <= `BAN_RST_PROTO;
      maxMaster <= `BAN_RST_MAXMST;
      objectId <= `BAN_RST_OBJID;
    end else if (wrStrobe) begin
      case (paddr)
        `BAN_OFS_NODE: nodeAddr <= wrData;
        `BAN_OFS_BAUD: baudCode <= wrData;
        `BAN_OFS_PROTO: protoCode <= wrData;
        `BAN_OFS_MAXMST: maxMaster <= next_maxMaster;
        `BAN_OFS_OBJID: objectId <= next_objectId;
        default: ;
      endcase
    end
  end

  // Message counter; only counts while a protocol is active
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msgCount <= 16'h0000;
    end else if (msgValid && protoSel != 2'(PROTO_OFF)) begin
      msgCount <= next_msgCount;
    end
  end

  // Registered effective settings toward the serial engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      effCfg <= '0;
      netEnable <= 1'b0;
    end else begin
      effCfg.proto <= bancfg_proto_type'(protoSel);
      effCfg.baud <= baudRate;
      effCfg.node <= nodeUsed;
      effCfg.maxMaster <= maxMaster;
      effCfg.objectId <= objectUsed;
      netEnable <= (protoSel != 2'(PROTO_OFF));
    end
  end

  // Checks
  sequence s_wrMax;
    wrStrobe && paddr == `BAN_OFS_MAXMST && wrData > 16'h007f;
  endsequence

  a_maxmaster_clamp: assert property (@(posedge clk) disable iff (sys_rst)
    s_wrMax |=> maxMaster == 16'h007f) else $error("max master not clamped");
  a_objid_force: assert property (@(posedge clk) disable iff (sys_rst)
    wrStrobe && paddr == `BAN_OFS_OBJID && $signed(wrData) < -16'sd19
    |=> objectId == 16'h0001) else $error("object id not forced");
  a_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    msgValid && netEnable && msgCount == 16'h270f && protoSel == effCfg.proto
    |=> msgCount == 16'h0000) else $error("counter did not wrap");
  a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
    msgValid && protoSel != 2'b00 && msgCount < 16'h270f
    |=> msgCount == $past(msgCount) + 16'h0001) else $error("counter did not step");
  a_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !msgValid |=> $stable(msgCount)) else $error("counter moved");
  a_count_range: assert property (@(posedge clk) disable iff (sys_rst)
    msgCount <= 16'h270f) else $error("counter above 9999");
  a_proto_off: assert property (@(posedge clk) disable iff (sys_rst)
    protoCode > 16'h0003 |=> !netEnable) else $error("network not disabled");
  a_baud_default: assert property (@(posedge clk) disable iff (sys_rst)
    (baudCode == 16'h0000 || baudCode > 16'h0008) && protoSel == 2'b10
    |=> effCfg.baud == 17'h0_2580) else $error("wrong BACnet default");
  a_baud_code: assert property (@(posedge clk) disable iff (sys_rst)
    baudCode == 16'h0001 |=> effCfg.baud == 17'h0_04b0) else $error("wrong 1200 rate");
  a_node_modbus: assert property (@(posedge clk) disable iff (sys_rst)
    protoSel == 2'b01 && (nodeAddr == 16'h0000 || nodeAddr > 16'h00f7)
    |=> effCfg.node == 16'h00f7) else $error("Modbus address not clamped");
  a_node_bacnet: assert property (@(posedge clk) disable iff (sys_rst)
    protoSel == 2'b10 && nodeAddr > 16'h007f
    |=> effCfg.node == 16'h007f) else $error("BACnet address not clamped");
  a_objid_node: assert property (@(posedge clk) disable iff (sys_rst)
    objectId == 16'h0000 |=> effCfg.objectId == $past(nodeUsed)) else $error("object id");
  a_ident_read: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && paddr == `BAN_OFS_IDENT |=> prdata == {16'h0000, IDENT_CODE})
    else $error("identification read wrong");
  a_ident_range: assert property (@(posedge clk) IDENT_CODE <= 16'h0257)
    else $error("identification out of range");
  a_fw_range: assert property (@(posedge clk) FW_MAJMIN <= 16'h270f && FW_SUB <= 16'h0063)
    else $error("firmware version out of range");
  a_proto_map: assert property (@(posedge clk) disable iff (sys_rst)
    protoCode == 16'h0002 |=> effCfg.proto == PROTO_BACNET) else $error("proto map");
endmodule : bancfg_bank
`default_nettype wire

// ==== bancfg_params.svh ====
// Constants of the network parameter bank: offsets, fields, resets, limits
// How it works
// - Protocol code 0 disables the network, 1 picks Modbus RTU, 2 BACnet, 3 the third protocol.
// - Any protocol code above 3 disables the network just like code 0.
// - Baud codes 1 to 8 map to 1200, 2400, 4800, 9600, 19200, 38400, 57600 and 76800 bps.
// - Baud code 0 or above 8 gives the protocol default: 19200, 9600 or 5000 bps.
// - Valid node addresses are 1-247 for Modbus RTU, 0-127 for BACnet, 1-255 for the third.
// - A node address outside the selected protocol's range is replaced by that range's maximum.
// - The read-only message counter steps once per valid received message, range 0 to 9999; the code counts only while protocol 1 to 3 is selected.
// - The counter returns to zero on the message after 9999 and at power-up.
// - In BACnet the max master setting, default 127, is the highest polled master address.
// - A max master write above 127 stores and uses 127, so a readback shows 127.
// - Firmware version xx.yy.zz reads as xx.yy (0.00-99.99, as x100) and zz (0-99).
// - A read-only identification field, 0 to 599, returns a fixed interface code.
// - A zero object identifier setting means the node address is used as BACnet object id.
// - An object identifier write below -19 stores 1 instead.
`ifndef BANCFG_PARAMS_SVH
`define BANCFG_PARAMS_SVH
`define BAN_OFS_IDENT 12'h000
`define BAN_OFS_FWMM 12'h004
`define BAN_OFS_FWSUB 12'h008
`define BAN_OFS_NODE 12'h00c
`define BAN_OFS_BAUD 12'h010
`define BAN_OFS_PROTO 12'h014
`define BAN_OFS_MSGCNT 12'h018
`define BAN_OFS_MAXMST 12'h01c
`define BAN_OFS_OBJID 12'h020
`define BAN_OFS_EFFNODE 12'h024
`define BAN_OFS_EFFCFG 12'h028
`define BAN_RST_NODE 16'h0000
`define BAN_RST_BAUD 16'h0000
`define BAN_RST_PROTO 16'h0000
`define BAN_RST_MAXMST 16'h007f
`define BAN_RST_OBJID 16'h0000
`define BAN_MAXMST_LIMIT 16'h007f
`define BAN_OBJID_MIN 16'hffed
`define BAN_OBJID_FORCED 16'h0001
`define BAN_CNT_MAX 16'h270f
`define BAN_MODBUS_MIN 16'h0001
`define BAN_MODBUS_MAX 16'h00f7
`define BAN_BACNET_MIN 16'h0000
`define BAN_BACNET_MAX 16'h007f
`define BAN_THIRD_MIN 16'h0001
`define BAN_THIRD_MAX 16'h00ff
`define BAN_BAUD_CODE_MAX 16'h0008
`define BAN_BAUD_DEF_MODBUS 17'h0_4b00
`define BAN_BAUD_DEF_BACNET 17'h0_2580
`define BAN_BAUD_DEF_THIRD 17'h0_1388
`define BAN_EFFCFG_PROTO_LSB 17
`endif

// ==== bancfg_pkg.sv ====
// Types shared by the network parameter bank
package bancfg_pkg;
  typedef enum logic [1:0] {
    PROTO_OFF,
    PROTO_MODBUS,
    PROTO_BACNET,
    PROTO_THIRD
  } bancfg_proto_type;

  typedef struct packed {
    bancfg_proto_type proto;
    logic [16:0] baud;
    logic [15:0] node;
    logic [15:0] maxMaster;
    logic [15:0] objectId;
  } bancfg_eff_type;
endpackage : bancfg_pkg

// ==== bancfg_resolve.sv ====
// Combinational decode of protocol, baud rate and effective node address
`timescale 1ns/1ps
`default_nettype none
`include "bancfg_params.svh"
module bancfg_resolve
  import bancfg_pkg::*;
(
  input wire logic [15:0] protoCode,
  input wire logic [15:0] baudCode,
  input wire logic [15:0] nodeAddr,
  output logic [1:0] protoSel,
  output logic [16:0] baudRate,
  output logic [15:0] nodeUsed
);
  // Rate table, one entry per code
  function automatic logic [16:0] baud_of(input logic [3:0] code);
    case (code)
      4'h1: baud_of = 17'h0_04b0;
      4'h2: baud_of = 17'h0_0960;
      4'h3: baud_of = 17'h0_12c0;
      4'h4: baud_of = 17'h0_2580;
      4'h5: baud_of = 17'h0_4b00;
      4'h6: baud_of = 17'h0_9600;
      4'h7: baud_of = 17'h0_e100;
      4'h8: baud_of = 17'h1_2c00;
      default: baud_of = 17'h0_0000;
    endcase
  endfunction : baud_of

  wire logic codeInRange;
  wire logic [16:0] defRate;
  wire logic [15:0] lo;
  wire logic [15:0] hi;
  wire logic outOfRange;

  // Codes above 3 read as off, like code 0
  assign protoSel = (protoCode > 16'h0003) ? 2'(PROTO_OFF) : protoCode[1:0];
  // Codes 0 and above 8 take the protocol default
  assign codeInRange = (baudCode != 16'h0000) && (baudCode <= `BAN_BAUD_CODE_MAX);
  assign defRate = (protoSel == 2'(PROTO_MODBUS)) ? `BAN_BAUD_DEF_MODBUS :
                   (protoSel == 2'(PROTO_BACNET)) ? `BAN_BAUD_DEF_BACNET :
                   (protoSel == 2'(PROTO_THIRD)) ? `BAN_BAUD_DEF_THIRD : 17'h0_0000;
  assign baudRate = codeInRange ? baud_of(baudCode[3:0]) : defRate;
  // Per-protocol address window; off uses the node value as is
  assign lo = (protoSel == 2'(PROTO_MODBUS)) ? `BAN_MODBUS_MIN :
              (protoSel == 2'(PROTO_BACNET)) ? `BAN_BACNET_MIN : `BAN_THIRD_MIN;
  assign hi = (protoSel == 2'(PROTO_MODBUS)) ? `BAN_MODBUS_MAX :
              (protoSel == 2'(PROTO_BACNET)) ? `BAN_BACNET_MAX : `BAN_THIRD_MAX;
  assign outOfRange = (protoSel != 2'(PROTO_OFF)) && ((nodeAddr < lo) || (nodeAddr > hi));
  assign nodeUsed = outOfRange ? hi : nodeAddr;
endmodule : bancfg_resolve
`default_nettype wire

// ==== bancfg_net_node.sv ====
// Network node model that delivers valid received-message pulses
`timescale 1ns/1ps
`default_nettype none
module bancfg_net_node (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] msgCount,
  input wire logic slow,
  output logic msgValid,
  output logic busy
);
  initial begin
    msgValid = 1'b0;
    busy = 1'b0;
  end
  // Burst of pulses; slow mode leaves an idle cycle between frames
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < msgCount; i++) begin
        msgValid <= 1'b1;
        @(posedge clk);
        if (slow) begin
          msgValid <= 1'b0;
          @(posedge clk);
        end
      end
      if (!slow) msgValid <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule : bancfg_net_node
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the network parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "bancfg_params.svh"
module tb_top
  import bancfg_pkg::*;
;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic msgValid, netEnable, go, slow, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, x;
  logic [15:0] msgCount, n;
  bancfg_eff_type effCfg;
  int error_cnt, comparisons;
  logic [16:0] rates [0:8];
  logic [16:0] defs [1:3];
  logic [15:0] nodeMax [1:3];
  logic [15:0] nodeMin [1:3];
  // Identity values are arbitrary
  bancfg_bank #(.IDENT_CODE(16'h0155), .FW_MAJMIN(16'h0102), .FW_SUB(16'h0007)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msgValid(msgValid), .effCfg(effCfg), .netEnable(netEnable));
  bancfg_net_node node_u (.clk(clk), .go(go), .msgCount(msgCount), .slow(slow),
    .msgValid(msgValid), .busy(busy));
  always #4 clk = ~clk;
  task close_out;
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; hold everything until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h0000_0000, 32'h0000_0001);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
    chk({31'h0, e}, 32'h0000_0000);
  endtask : rd
  // Bounded wait so a stuck model cannot hang the run
  task send(input logic [15:0] c, input logic s);
    int k;
    msgCount <= c; slow <= s; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    @(posedge clk);
    while (busy !== 1'b0 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 30000) chk(32'h0000_0000, 32'h0000_0001);
  endtask : send
  initial begin
    #(8 * 80000);
    error_cnt++;
    close_out();
  end
  initial begin
    clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    go = 0; slow = 0; msgCount = 0; n = 0; error_cnt = 0; comparisons = 0;
    rates = '{17'h0_0000, 17'h0_04b0, 17'h0_0960, 17'h0_12c0, 17'h0_2580,
      17'h0_4b00, 17'h0_9600, 17'h0_e100, 17'h1_2c00};
    defs = '{17'h0_4b00, 17'h0_2580, 17'h0_1388};
    nodeMax = '{16'h00f7, 16'h007f, 16'h00ff};
    nodeMin = '{16'h0001, 16'h0000, 16'h0001};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`BAN_OFS_IDENT, 32'h0000_0155);
    rd(`BAN_OFS_FWMM, 32'h0000_0102);
    rd(`BAN_OFS_FWSUB, 32'h0000_0007);
    rd(`BAN_OFS_MAXMST, 32'h0000_007f);
    rd(`BAN_OFS_MSGCNT, 32'h0000_0000);
    rd(`BAN_OFS_PROTO, 32'h0000_0000);
    wr(`BAN_OFS_IDENT, 32'h0000_0001);
    rd(`BAN_OFS_IDENT, 32'h0000_0155);
    // Unmapped offset is refused
    apb(1'b0, 12'h02c, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    for (int p = 0; p < 6; p++) begin
      wr(`BAN_OFS_PROTO, (p == 5) ? 32'h0000_ffff : p);
      rd(`BAN_OFS_NODE, 32'h0000_0000);
      chk({31'h0, netEnable}, (p >= 1 && p <= 3));
    end
    // Every baud code and node edge under each protocol
    for (int p = 1; p < 4; p++) begin
      wr(`BAN_OFS_PROTO, p);
      for (int b = 0; b < 10; b++) begin
        wr(`BAN_OFS_BAUD, b);
        // Expected from the rate tables; the registered copy must agree a cycle later
        x = {13'h0, p[1:0], (b >= 1 && b <= 8) ? rates[b] : defs[p]};
        rd(`BAN_OFS_EFFCFG, x);
        chk({13'h0, effCfg.proto, effCfg.baud}, x);
      end
      for (int k = 0; k < 5; k++) begin
        n = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0001 : (k == 2) ? nodeMax[p] :
          (k == 3) ? nodeMax[p] + 16'h0001 : 16'hffff;
        wr(`BAN_OFS_NODE, {16'h0, n});
        x = {16'h0, (n < nodeMin[p] || n > nodeMax[p]) ? nodeMax[p] : n};
        rd(`BAN_OFS_EFFNODE, x);
        chk({16'h0, effCfg.node}, x);
      end
    end
    wr(`BAN_OFS_MAXMST, 32'h0000_00c8);
    rd(`BAN_OFS_MAXMST, 32'h0000_007f);
    wr(`BAN_OFS_MAXMST, 32'h0000_0080);
    rd(`BAN_OFS_MAXMST, 32'h0000_007f);
    wr(`BAN_OFS_MAXMST, 32'h0000_0005);
    rd(`BAN_OFS_MAXMST, 32'h0000_0005);
    chk({16'h0, effCfg.maxMaster}, 32'h0000_0005);
    wr(`BAN_OFS_PROTO, 32'h0000_0002);
    wr(`BAN_OFS_NODE, 32'h0000_0005);
    rd(`BAN_OFS_OBJID, 32'h0000_0000);
    chk({16'h0, effCfg.objectId}, 32'h0000_0005);
    wr(`BAN_OFS_OBJID, 32'h0000_ffec);
    rd(`BAN_OFS_OBJID, 32'h0000_0001);
    chk({16'h0, effCfg.objectId}, 32'h0000_0001);
    wr(`BAN_OFS_OBJID, 32'h0000_8000);
    rd(`BAN_OFS_OBJID, 32'h0000_0001);
    wr(`BAN_OFS_OBJID, 32'h0000_ffed);
    rd(`BAN_OFS_OBJID, 32'h0000_ffed);
    // Counter ignores traffic while off, then wraps after 9999
    wr(`BAN_OFS_PROTO, 32'h0000_0000);
    send(16'h0003, 1'b1);
    rd(`BAN_OFS_MSGCNT, 32'h0000_0000);
    wr(`BAN_OFS_PROTO, 32'h0000_0001);
    send(16'h270f, 1'b0);
    rd(`BAN_OFS_MSGCNT, 32'h0000_270f);
    send(16'h0001, 1'b1);
    rd(`BAN_OFS_MSGCNT, 32'h0000_0000);
    send(16'h0002, 1'b1);
    rd(`BAN_OFS_MSGCNT, 32'h0000_0002);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`BAN_OFS_MSGCNT, 32'h0000_0000);
    rd(`BAN_OFS_MAXMST, 32'h0000_007f);
    chk({31'h0, netEnable}, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
